// ### logic/ipve_encoder.sv
// interrupt priority encoder with vector and source mirror registers
`include "ipve_params.svh"
module ipve_encoder (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic normal_mode,
    input wire logic stop_wake,
    input wire logic [4:0] voltage_cond,
    input wire logic [4:0] timer_irq,
    input wire logic [2:0] serial_irq,
    input wire logic adc_sequence_done_irq,
    input wire logic [3:0] overtemp_cond,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [7:0] rd_addr,
    input wire logic voltage_status_rd,
    input wire logic lin_status_rd,
    input wire logic high_side_status_rd,
    input wire logic low_side_status_rd,
    input wire logic hall_supply_rd,
    output ipve_pkg::ipve_byte_t rd_data,
    output ipve_pkg::ipve_byte_t interrupt_vector_reg,
    output logic [15:0] source_mirror_reg,
    output logic die_link_irq_out
);
    import ipve_pkg::*;

    // voltage_cond bits: 0 low volt, 1 reg hot, 2 low batt, 3 high volt, 4 reg overvolt
    // overtemp_cond bits: 0 lin, 1 high side, 2 low side, 3 hall supply

    ////////////////////////////////////////////////////////////////////////
    // condition-based sources: latched on rising edge, cleared by owner read
    logic [8:0] cond_sync1_reg, cond_sync2_reg, cond_prev_reg;
    logic [8:0] cond_sync1_next, cond_sync2_next, cond_prev_next;
    logic [8:0] cond_pend_reg, cond_pend_next;
    logic [8:0] ack_vec;

    always_comb begin
        ack_vec = {{4{1'b0}}, {5{voltage_status_rd}}}; // R14
        ack_vec[5] = lin_status_rd; // R16
        ack_vec[6] = high_side_status_rd; // R17
        ack_vec[7] = low_side_status_rd; // R18
        ack_vec[8] = hall_supply_rd; // R19
        cond_sync1_next = {overtemp_cond, voltage_cond};
        cond_sync2_next = cond_sync1_reg;
        cond_prev_next = cond_sync2_reg;
        // set beats clear; a level held high never re-arms by itself
        cond_pend_next = (cond_pend_reg & ~ack_vec) | (cond_sync2_reg & ~cond_prev_reg); // R15
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cond_sync1_reg <= '0;
            cond_sync2_reg <= '0;
            cond_prev_reg <= '0;
            cond_pend_reg <= '0;
        end else begin
            cond_sync1_reg <= cond_sync1_next;
            cond_sync2_reg <= cond_sync2_next;
            cond_prev_reg <= cond_prev_next;
            cond_pend_reg <= cond_pend_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // peripheral request levels, owned and cleared by their units
    logic [8:0] per_sync1_reg, per_sync2_reg;
    logic [8:0] per_sync1_next, per_sync2_next;
    logic stop_sync1_reg, stop_sync2_reg, norm_sync1_reg, norm_sync2_reg;
    logic stop_sync1_next, stop_sync2_next, norm_sync1_next, norm_sync2_next;

    always_comb begin
        per_sync1_next = {adc_sequence_done_irq, serial_irq, timer_irq};
        per_sync2_next = per_sync1_reg;
        stop_sync1_next = stop_wake;
        stop_sync2_next = stop_sync1_reg;
        norm_sync1_next = normal_mode;
        norm_sync2_next = norm_sync1_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            per_sync1_reg <= '0;
            per_sync2_reg <= '0;
            stop_sync1_reg <= 1'b0;
            stop_sync2_reg <= 1'b0;
            norm_sync1_reg <= 1'b0;
            norm_sync2_reg <= 1'b0;
        end else begin
            per_sync1_reg <= per_sync1_next;
            per_sync2_reg <= per_sync2_next;
            stop_sync1_reg <= stop_sync1_next;
            stop_sync2_reg <= stop_sync2_next;
            norm_sync1_reg <= norm_sync1_next;
            norm_sync2_reg <= norm_sync2_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // priority encode; index order is priority order
    function automatic ipve_byte_t ipve_encode(input ipve_src_t p);
        ipve_byte_t code;
        code = `IPVE_NONE;
        for (int i = `IPVE_NSRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                code = {1'b0, 6'(i + 1), 1'b0}; // R2 R6
            end
        end
        return code;
    endfunction

    ipve_src_t pend;
    logic [15:0] mirror_next;
    ipve_byte_t vector_next, rd_data_next;
    logic irq_next;

    always_comb begin
        // summary bit is not a source here, only a mirror bit
        pend = '0; // R13
        pend[`IPVE_SRC_LVI] = cond_pend_reg[0]; // R7
        pend[`IPVE_SRC_HTI] = cond_pend_reg[1];
        pend[`IPVE_SRC_LBI] = cond_pend_reg[2];
        pend[`IPVE_SRC_TMR +: 5] = per_sync2_reg[4:0]; // R8
        pend[`IPVE_SRC_SER +: 3] = per_sync2_reg[7:5]; // R9
        pend[`IPVE_SRC_ADC] = per_sync2_reg[8]; // R10
        pend[`IPVE_SRC_LIN] = cond_pend_reg[5];
        pend[`IPVE_SRC_HIGH_SIDE_OVERTEMP_IRQ] = cond_pend_reg[6];
        pend[`IPVE_SRC_LOW_SIDE_OVERTEMP_IRQ] = cond_pend_reg[7];
        pend[`IPVE_SRC_HOT] = cond_pend_reg[8];
        pend[`IPVE_SRC_HVI] = cond_pend_reg[3]; // R11
        pend[`IPVE_SRC_VROV] = cond_pend_reg[4];
        mirror_next = '0; // R21
        mirror_next[`IPVE_M_VSI] = |cond_pend_reg[4:0];
        mirror_next[`IPVE_M_TMR +: 5] = per_sync2_reg[4:0];
        mirror_next[`IPVE_M_SER +: 3] = per_sync2_reg[7:5];
        mirror_next[`IPVE_M_ADC] = per_sync2_reg[8];
        mirror_next[`IPVE_M_OT +: 4] = cond_pend_reg[8:5];
        if (stop_sync2_reg) begin
            vector_next = `IPVE_NONE; // R5
        end else begin
            vector_next = ipve_encode(pend); // R1 R6 R22 R23
        end
        irq_next = norm_sync2_reg && (|pend); // R20
        // reads only observe; writes never reach any state
        // reads return the registered copies so data matches what the pins show
        rd_data_next = rd_data; // R3 R22
        if (rd_strobe && !wr_strobe) begin
            case (rd_addr)
                `IPVE_OFF_MIRROR_LO: rd_data_next = source_mirror_reg[7:0];
                `IPVE_OFF_MIRROR_HI: rd_data_next = source_mirror_reg[15:8];
                `IPVE_OFF_VECTOR: rd_data_next = interrupt_vector_reg; // R12
                default: rd_data_next = `IPVE_NONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            interrupt_vector_reg <= `IPVE_NONE;
            source_mirror_reg <= '0;
            die_link_irq_out <= 1'b0;
            rd_data <= `IPVE_NONE;
        end else begin
            interrupt_vector_reg <= vector_next;
            source_mirror_reg <= mirror_next;
            die_link_irq_out <= irq_next;
            rd_data <= rd_data_next;
        end
    end
endmodule

// ### logic/ipve_params.svh
// constants of the interrupt priority vector encoder
// Function
// R1 - vector register reports top pending code
// R2 - codes pre-shifted, always even
// R3 - vector read has no side effect
// R4 - host then reads owning status register
// R5 - nothing pending or stop wake reads zero
// R6 - smallest nonzero code wins
// R7 - voltage codes 0x02 0x04 0x06
// R8 - timer codes 0x08 to 0x10
// R9 - serial codes 0x12 0x14 0x16
// R10 - adc and overtemp codes 0x18 to 0x20
// R11 - high voltage 0x22, overvoltage 0x24
// R12 - vector at offset 0x02 of window
// R13 - voltage summary never encoded
// R14 - voltage status read acks voltage sources
// R15 - rearm only after condition vanishes
// R16 - lin status read acks lin overtemp
// R17 - high side status read acks hs overtemp
// R18 - low side status read acks ls overtemp
// R19 - hall supply read acks hall overtemp
// R20 - irq out high while pending, normal mode
// R21 - source mirror read-only, no ack
// R22 - vector upper bits zero, writes ignored
// R23 - vector tracks pending set within one clock
`ifndef IPVE_PARAMS_SVH
`define IPVE_PARAMS_SVH
`define IPVE_OFF_MIRROR_LO 8'h00
`define IPVE_OFF_MIRROR_HI 8'h01
`define IPVE_OFF_VECTOR 8'h02
`define IPVE_BASE_BLOCKING 16'h0200
`define IPVE_BASE_NONBLOCKING 16'h0300
`define IPVE_NSRC 18
`define IPVE_NONE 8'h00
`define IPVE_SRC_LVI 0
`define IPVE_SRC_HTI 1
`define IPVE_SRC_LBI 2
`define IPVE_SRC_TMR 3
`define IPVE_SRC_SER 8
`define IPVE_SRC_ADC 11
`define IPVE_SRC_LIN 12
`define IPVE_SRC_HIGH_SIDE_OVERTEMP_IRQ 13
`define IPVE_SRC_LOW_SIDE_OVERTEMP_IRQ 14
`define IPVE_SRC_HOT 15
`define IPVE_SRC_HVI 16
`define IPVE_SRC_VROV 17
`define IPVE_M_VSI 0
`define IPVE_M_TMR 1
`define IPVE_M_SER 6
`define IPVE_M_ADC 9
`define IPVE_M_OT 10
`endif

// ### logic/ipve_pkg.sv
// types of the interrupt priority vector encoder
package ipve_pkg;
    typedef logic [7:0] ipve_byte_t;
    typedef logic [17:0] ipve_src_t;
endpackage

// ### verification/ipve_asserts.sv
// port assertions for the interrupt priority vector encoder
module ipve_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic normal_mode,
    input wire logic stop_wake,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [7:0] rd_addr,
    input wire ipve_pkg::ipve_byte_t rd_data,
    input wire ipve_pkg::ipve_byte_t interrupt_vector_reg,
    input wire logic [15:0] source_mirror_reg,
    input wire logic die_link_irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import ipve_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // four edges cover the two sync stages plus the output register
    sequence no_stop;
        !stop_wake [*4];
    endsequence
    ////////////////////////////////////////////////////////////////
    even_vector_a: assert property (interrupt_vector_reg[0] == 1'b0)
        else $error("vector code is odd");
    vector_top_a: assert property (interrupt_vector_reg[7:6] == 2'b00)
        else $error("vector upper bits set");
    code_range_a: assert property (interrupt_vector_reg <= 8'h24)
        else $error("vector code out of range");
    idle_zero_a: assert property (source_mirror_reg == 16'h0000 |-> interrupt_vector_reg == 8'h00)
        else $error("vector nonzero with nothing pending");
    irq_cause_a: assert property (die_link_irq_out |-> source_mirror_reg != 16'h0000)
        else $error("irq without pending source");
    irq_mode_a: assert property (!normal_mode [*4] |-> !die_link_irq_out)
        else $error("irq outside normal mode");
    stop_zero_a: assert property (stop_wake [*4] |-> interrupt_vector_reg == 8'h00)
        else $error("vector nonzero after stop wake");
    timer_code_a: assert property (no_stop ##0 (source_mirror_reg[1:0] == 2'b10)
        |-> interrupt_vector_reg == 8'h08)
        else $error("timer channel zero not encoded");
    vector_read_a: assert property (rd_strobe && !wr_strobe && rd_addr == 8'h02
        |=> rd_data == $past(interrupt_vector_reg))
        else $error("vector read returned wrong data");
endmodule
bind ipve_encoder ipve_asserts i_chk (.clk(clk), .sys_rst(sys_rst),
    .normal_mode(normal_mode), .stop_wake(stop_wake), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
    .interrupt_vector_reg(interrupt_vector_reg), .source_mirror_reg(source_mirror_reg),
    .die_link_irq_out(die_link_irq_out));

// ### verification/ipve_host_model.sv
// microcontroller model issuing window reads, writes and status-read acks
module ipve_host_model (
    input wire logic clk,
    output logic rd_strobe,
    output logic wr_strobe,
    output logic [7:0] rd_addr,
    output logic [4:0] ack
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        rd_addr = 8'hFF;
        ack = 5'h00;
    end
    // idle address inverted from the access offset; an 8'hFF access idles at 0x00, a valid offset
    task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [4:0] k);
        rd_strobe <= r;
        wr_strobe <= w;
        rd_addr <= a;
        ack <= k;
        @(posedge clk);
        rd_strobe <= 1'b0;
        wr_strobe <= 1'b0;
        rd_addr <= ~a;
        ack <= 5'h00;
        @(posedge clk);
        #1;
    endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the interrupt priority vector encoder
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ipve_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, normal_mode = 1'b1, stop_wake = 1'b0, adc = 1'b0;
    logic [4:0] vc = 5'h00, tm = 5'h00;
    logic [2:0] sr = 3'h0;
    logic [3:0] ot = 4'h0;
    logic rs, ws, irq;
    logic [7:0] ra;
    logic [4:0] ak;
    logic [15:0] mir;
    ipve_byte_t rdd, vec;
    int miscompares = 0, num_checks = 0;
    always #10 clk = ~clk;
    ipve_host_model i_host (.clk(clk), .rd_strobe(rs), .wr_strobe(ws), .rd_addr(ra), .ack(ak));
    ipve_encoder i_dut (.clk(clk), .sys_rst(sys_rst), .normal_mode(normal_mode),
        .stop_wake(stop_wake), .voltage_cond(vc), .timer_irq(tm), .serial_irq(sr),
        .adc_sequence_done_irq(adc), .overtemp_cond(ot), .rd_strobe(rs), .wr_strobe(ws),
        .rd_addr(ra), .voltage_status_rd(ak[0]), .lin_status_rd(ak[1]),
        .high_side_status_rd(ak[2]), .low_side_status_rd(ak[3]), .hall_supply_rd(ak[4]),
        .rd_data(rdd), .interrupt_vector_reg(vec), .source_mirror_reg(mir),
        .die_link_irq_out(irq));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // bit order follows the priority table, index 0 highest
    task automatic src(input logic [17:0] s);
        @(posedge clk);
        vc <= {s[17:16], s[2:0]};
        tm <= s[7:3];
        sr <= s[10:8];
        adc <= s[11];
        ot <= s[15:12];
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100us;
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        src(18'h00000);
        chk(vec, 16'h0000);
        for (int i = 0; i < 18; i++) begin
            src(18'h1 << i);
            chk(vec, 16'((i + 1) * 2));
            chk(irq, 16'h0001);
            src(18'h00000);
            i_host.acc(1'b0, 1'b0, 8'hFF, 5'h1F);
        end
        src(18'h3FFFF);
        chk(mir, 16'h3FFF);
        i_host.acc(1'b1, 1'b0, 8'h02, 5'h00);
        chk(rdd, 16'h0002);
        chk(vec, 16'h0002);
        i_host.acc(1'b0, 1'b1, 8'h02, 5'h00);
        i_host.acc(1'b1, 1'b0, 8'h02, 5'h00);
        chk(rdd, 16'h0002);
        i_host.acc(1'b1, 1'b0, 8'h05, 5'h00);
        chk(rdd, 16'h0000);
        i_host.acc(1'b0, 1'b0, 8'hFF, 5'h01);
        chk(vec, 16'h0008);
        src(18'h3F007);
        chk(vec, 16'h001A);
        for (int k = 1; k < 5; k++) begin
            i_host.acc(1'b0, 1'b0, 8'hFF, 5'(1 << k));
            chk(vec, (k < 4) ? 16'(8'h1A + 2 * k) : 16'h0000);
        end
        src(18'h00000);
        src(18'h00001);
        chk(vec, 16'h0002);
        stop_wake <= 1'b1;
        normal_mode <= 1'b0;
        src(18'h00001);
        chk(vec, 16'h0000);
        chk(irq, 16'h0000);
        finish_test();
    end
endmodule
